// ===== hw/bt_pkg.sv
/*
  Constants and types shared by both ends of the block-transfer buffer link.
  Assumes a single 100 MHz clock mclk and active-low asynchronous reset nrst.
*/
package bt_pkg;

  // ***************************************************************
  // Widths and depths
  // ***************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int USR_W = 3;
  localparam int RSV_W = 2;
  localparam int CFG_W = 3;
  localparam int IRQ_W = 4;

  typedef logic [DATA_W-1:0] byte_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [PTR_W-1:0] ptr_t;
  typedef logic [CNT_W-1:0] cnt_t;

  // ***************************************************************
  // Addresses seen from the host link and from the slave port
  // ***************************************************************
  localparam addr_t LNK_CTRL = 3'h0;
  localparam addr_t LNK_DATA = 3'h1;
  localparam addr_t LNK_MASK = 3'h2;
  localparam addr_t SLV_CFG = 3'h3;
  localparam addr_t SLV_IRQ_STAT = 3'h4;
  localparam addr_t SLV_IRQ_MASK = 3'h5;
  localparam addr_t SLV_LVL_H2S = 3'h6;
  localparam addr_t SLV_LVL_S2H = 3'h7;
  localparam addr_t HST_WR_CNT = 3'h4;
  localparam addr_t HST_RD_CNT = 3'h5;

  // ***************************************************************
  // Field positions and values
  // ***************************************************************
  localparam int CLR_WR_BIT = 0;
  localparam int CLR_RD_BIT = 1;
  localparam int USR_LO = 2;
  localparam int RSV_LO = 5;
  localparam int RST_REQ_BIT = 7;
  localparam int CFG_SEL_LOW = 0;
  localparam int CFG_SEL_HIGH = 1;
  localparam int CFG_RB_EN = 2;
  localparam int IRQ_WR_CLR = 0;
  localparam int IRQ_RD_CLR = 1;
  localparam int IRQ_RST = 2;
  localparam int IRQ_HDATA = 3;
  localparam logic [1:0] FIFO_ON = 2'h3;
  localparam byte_t BYTE_ZERO = 8'h00;
  localparam cnt_t CNT_FULL = 7'h40;
  localparam cnt_t CNT_ZERO = 7'h00;
  localparam ptr_t PTR_ZERO = 6'h00;
  localparam ptr_t PTR_ONE = 6'h01;
  localparam cnt_t CNT_ONE = 7'h01;

  function automatic ptr_t ptrInc(input ptr_t p);
    ptrInc = p + PTR_ONE;
  endfunction : ptrInc

  function automatic cnt_t cntNext(input cnt_t c, input logic push,
                                   input logic pop);
    cntNext = c;
    if (push && !pop) begin
      cntNext = c + CNT_ONE;
    end else if (pop && !push) begin
      cntNext = c - CNT_ONE;
    end
  endfunction : cntNext

endpackage : bt_pkg

// ===== hw/bt_link_if.sv
/*
  Host bus link between the external host end and the buffer device end.
  Assumes both ends run on the same mclk; read data follows one cycle later.
*/
interface bt_link_if;
  logic [bt_pkg::ADDR_W-1:0] addr;
  logic [bt_pkg::DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [bt_pkg::DATA_W-1:0] rdata;

  modport hostEnd (output addr, output wdata, output wr, output rd,
                   input rdata);
  modport devEnd (input addr, input wdata, input wr, input rd,
                  output rdata);
endinterface : bt_link_if

// ===== hw/block_transfer_host_buffer.sv
/*
  Device end of the block-transfer host buffer: pointer-clear requests,
  two 64-byte FIFOs, the upper host interrupt mask control bits, and a
  slave-side register port with a level interrupt.
  Assumes the host link and the slave port share mclk; strobes are single
  cycle and never both set on one port at once.
*/
// Implementation choices: strobed register access and the register addresses.
// What this block does
// RULE_01 - Host write 1 sets read-pointer clear; reads 0
// RULE_02 - Slave write 0 clears read-pointer clear
// RULE_03 - Host write 1 sets write-pointer clear; reads 0
// RULE_04 - Slave write 0 clears write-pointer clear
// RULE_05 - Pending clear holds matching FIFO pointers zero
// RULE_06 - Two independent 64-byte FIFOs, one per direction
// RULE_07 - Software enables FIFO via both select bits
// RULE_08 - Host-written bytes reach slave in order
// RULE_09 - Slave-written bytes reach host in order
// RULE_10 - Host write 1 to bit 7 sets reset
// RULE_11 - Reset flag reads 0 to host unless readback enabled
// RULE_12 - Slave writes 0 to cancel the reset
// RULE_13 - Host write 0 sets user bits 4..2
// RULE_14 - Slave writes user bits directly, both values
// RULE_15 - Bits 6..5 reserved, reset 0, shared read/write
module block_transfer_host_buffer (
  input wire logic mclk,
  input wire logic nrst,
  bt_link_if.devEnd lnk,
  input wire bt_pkg::addr_t sAddr,
  input wire bt_pkg::byte_t sWdata,
  input wire logic sWr,
  input wire logic sRd,
  output bt_pkg::byte_t sRdata,
  output logic slaveReset,
  output logic irq
);
  import bt_pkg::*;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic hWrCtrl, hWrData, hWrMask, hRdData;
  logic sWrCtrl, sWrData, sWrMask, sRdData, sWrCfg, sWrStat, sWrIrqMask;
  logic fifoOn;
  logic clrRd_q, clrWr_q, resetReq_q;
  logic [RSV_W-1:0] rsv_q;
  logic [USR_W-1:0] user_q;
  logic [CFG_W-1:0] cfg_q;
  logic [IRQ_W-1:0] irqStat_q, irqMask_q, evt, irqClr;

  assign hWrCtrl = lnk.wr && (lnk.addr == LNK_CTRL);
  assign hWrData = lnk.wr && (lnk.addr == LNK_DATA);
  assign hWrMask = lnk.wr && (lnk.addr == LNK_MASK);
  assign hRdData = lnk.rd && (lnk.addr == LNK_DATA);
  assign sWrCtrl = sWr && (sAddr == LNK_CTRL);
  assign sWrData = sWr && (sAddr == LNK_DATA);
  assign sWrMask = sWr && (sAddr == LNK_MASK);
  assign sRdData = sRd && (sAddr == LNK_DATA);
  assign sWrCfg = sWr && (sAddr == SLV_CFG);
  assign sWrStat = sWr && (sAddr == SLV_IRQ_STAT);
  assign sWrIrqMask = sWr && (sAddr == SLV_IRQ_MASK);
  // Data accesses are ignored until both select bits are set
  assign fifoOn = (cfg_q[CFG_SEL_HIGH:CFG_SEL_LOW] == FIFO_ON); // see RULE_07

  // ***************************************************************
  // Pointer-clear requests
  // ***************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clrRd_q <= 1'b0;
    end else if (hWrCtrl && lnk.wdata[CLR_RD_BIT]) begin
      clrRd_q <= 1'b1; // see RULE_01
    end else if (sWrCtrl && !sWdata[CLR_RD_BIT]) begin
      clrRd_q <= 1'b0; // see RULE_02
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clrWr_q <= 1'b0;
    end else if (hWrCtrl && lnk.wdata[CLR_WR_BIT]) begin
      clrWr_q <= 1'b1; // see RULE_03
    end else if (sWrCtrl && !sWdata[CLR_WR_BIT]) begin
      clrWr_q <= 1'b0; // see RULE_04
    end
  end

  // ***************************************************************
  // Host interrupt mask control, upper bits
  // ***************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      resetReq_q <= 1'b0;
    end else if (hWrMask && lnk.wdata[RST_REQ_BIT]) begin
      resetReq_q <= 1'b1; // see RULE_10
    end else if (sWrMask && !sWdata[RST_REQ_BIT]) begin
      resetReq_q <= 1'b0; // see RULE_12
    end
  end

  // Host wins when both sides write the reserved bits together
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rsv_q <= '0;
    end else if (hWrMask) begin
      rsv_q <= lnk.wdata[RSV_LO +: RSV_W]; // see RULE_15
    end else if (sWrMask) begin
      rsv_q <= sWdata[RSV_LO +: RSV_W]; // see RULE_15
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      user_q <= '0;
    end else begin
      for (int i = 0; i < USR_W; i++) begin
        if (hWrMask && !lnk.wdata[USR_LO+i]) begin
          user_q[i] <= 1'b1; // see RULE_13
        end else if (sWrMask) begin
          user_q[i] <= sWdata[USR_LO+i]; // see RULE_14
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= '0;
    end else if (sWrCfg) begin
      cfg_q <= sWdata[CFG_W-1:0];
    end
  end

  function automatic byte_t maskView(input logic showReset);
    maskView = {showReset, rsv_q, user_q, 2'b00};
  endfunction : maskView

  // ***************************************************************
  // Host-to-slave FIFO
  // ***************************************************************
  byte_t h2sMem [FIFO_DEPTH]; // see RULE_06
  ptr_t h2sWp_q, h2sRp_q;
  cnt_t h2sCnt_q;
  logic h2sPush, h2sPop;

  assign h2sPush = hWrData && fifoOn && (h2sCnt_q != CNT_FULL) && !clrWr_q;
  assign h2sPop = sRdData && fifoOn && (h2sCnt_q != CNT_ZERO) && !clrWr_q;

  always_ff @(posedge mclk) begin
    if (h2sPush) begin
      h2sMem[h2sWp_q] <= lnk.wdata; // see RULE_08
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      h2sWp_q <= PTR_ZERO;
      h2sRp_q <= PTR_ZERO;
      h2sCnt_q <= CNT_ZERO;
    end else if (clrWr_q) begin
      h2sWp_q <= PTR_ZERO; // see RULE_05
      h2sRp_q <= PTR_ZERO; // see RULE_05
      h2sCnt_q <= CNT_ZERO;
    end else begin
      if (h2sPush) begin
        h2sWp_q <= ptrInc(h2sWp_q); // see RULE_08
      end
      if (h2sPop) begin
        h2sRp_q <= ptrInc(h2sRp_q); // see RULE_08
      end
      h2sCnt_q <= cntNext(h2sCnt_q, h2sPush, h2sPop);
    end
  end

  // ***************************************************************
  // Slave-to-host FIFO
  // ***************************************************************
  byte_t s2hMem [FIFO_DEPTH]; // see RULE_06
  ptr_t s2hWp_q, s2hRp_q;
  cnt_t s2hCnt_q;
  logic s2hPush, s2hPop;

  assign s2hPush = sWrData && fifoOn && (s2hCnt_q != CNT_FULL) && !clrRd_q;
  assign s2hPop = hRdData && fifoOn && (s2hCnt_q != CNT_ZERO) && !clrRd_q;

  always_ff @(posedge mclk) begin
    if (s2hPush) begin
      s2hMem[s2hWp_q] <= sWdata; // see RULE_09
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s2hWp_q <= PTR_ZERO;
      s2hRp_q <= PTR_ZERO;
      s2hCnt_q <= CNT_ZERO;
    end else if (clrRd_q) begin
      s2hWp_q <= PTR_ZERO; // see RULE_05
      s2hRp_q <= PTR_ZERO; // see RULE_05
      s2hCnt_q <= CNT_ZERO;
    end else begin
      if (s2hPush) begin
        s2hWp_q <= ptrInc(s2hWp_q); // see RULE_09
      end
      if (s2hPop) begin
        s2hRp_q <= ptrInc(s2hRp_q); // see RULE_09
      end
      s2hCnt_q <= cntNext(s2hCnt_q, s2hPush, s2hPop);
    end
  end

  // ***************************************************************
  // Read data, one cycle after the strobe
  // ***************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lnk.rdata <= BYTE_ZERO;
    end else if (!lnk.rd) begin
      lnk.rdata <= BYTE_ZERO;
    end else if (lnk.addr == LNK_DATA) begin
      lnk.rdata <= s2hPop ? s2hMem[s2hRp_q] : BYTE_ZERO; // see RULE_09
    end else if (lnk.addr == LNK_MASK) begin
      lnk.rdata <= maskView(resetReq_q && cfg_q[CFG_RB_EN]); // see RULE_11
    end else begin
      // Pointer-clear bits always read back as zero to the host
      lnk.rdata <= BYTE_ZERO; // see RULE_01, see RULE_03
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sRdata <= BYTE_ZERO;
    end else if (!sRd) begin
      sRdata <= BYTE_ZERO;
    end else if (sAddr == LNK_CTRL) begin
      sRdata <= {6'h00, clrRd_q, clrWr_q};
    end else if (sAddr == LNK_DATA) begin
      sRdata <= h2sPop ? h2sMem[h2sRp_q] : BYTE_ZERO; // see RULE_08
    end else if (sAddr == LNK_MASK) begin
      sRdata <= maskView(resetReq_q);
    end else if (sAddr == SLV_CFG) begin
      sRdata <= {5'h00, cfg_q};
    end else if (sAddr == SLV_IRQ_STAT) begin
      sRdata <= {4'h0, irqStat_q};
    end else if (sAddr == SLV_IRQ_MASK) begin
      sRdata <= {4'h0, irqMask_q};
    end else if (sAddr == SLV_LVL_H2S) begin
      sRdata <= {1'b0, h2sCnt_q};
    end else begin
      sRdata <= {1'b0, s2hCnt_q};
    end
  end

  // ***************************************************************
  // Slave interrupt: sticky events, write one to clear, set wins
  // ***************************************************************
  always_comb begin
    evt = '0;
    evt[IRQ_WR_CLR] = hWrCtrl && lnk.wdata[CLR_WR_BIT];
    evt[IRQ_RD_CLR] = hWrCtrl && lnk.wdata[CLR_RD_BIT];
    evt[IRQ_RST] = hWrMask && lnk.wdata[RST_REQ_BIT];
    evt[IRQ_HDATA] = h2sPush;
  end

  assign irqClr = sWrStat ? sWdata[IRQ_W-1:0] : '0;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | evt;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irqMask_q <= '0;
    end else if (sWrIrqMask) begin
      irqMask_q <= sWdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irqStat_q & irqMask_q);
  assign slaveReset = resetReq_q;

endmodule : block_transfer_host_buffer

// ===== hw/bt_host_end.sv
/*
  Host end of the block-transfer link: relays software accesses onto the
  host bus and keeps its own byte counters for the data buffer.
  Assumes the device answers link reads in the next cycle on the same mclk.
*/
module bt_host_end (
  input wire logic mclk,
  input wire logic nrst,
  bt_link_if.hostEnd lnk,
  input wire bt_pkg::addr_t uAddr,
  input wire bt_pkg::byte_t uWdata,
  input wire logic uWr,
  input wire logic uRd,
  output bt_pkg::byte_t uRdata
);
  import bt_pkg::*;

  // ***************************************************************
  // Link request path
  // ***************************************************************
  function automatic logic isLink(input addr_t a);
    isLink = (a == LNK_CTRL) || (a == LNK_DATA) || (a == LNK_MASK);
  endfunction : isLink

  byte_t wrCount_q, rdCount_q, ownData_q;
  logic ownSel_q;

  assign lnk.addr = uAddr;
  // Pointer-clear and reset requests go out as host writes of one
  assign lnk.wdata = uWdata; // see RULE_01, see RULE_03, see RULE_10
  assign lnk.wr = uWr && isLink(uAddr);
  assign lnk.rd = uRd && isLink(uAddr);

  // ***************************************************************
  // Own byte counters, cleared by any write to them
  // ***************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrCount_q <= BYTE_ZERO;
    end else if (uWr && (uAddr == HST_WR_CNT)) begin
      wrCount_q <= BYTE_ZERO;
    end else if (uWr && (uAddr == LNK_DATA)) begin
      wrCount_q <= wrCount_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdCount_q <= BYTE_ZERO;
    end else if (uWr && (uAddr == HST_RD_CNT)) begin
      rdCount_q <= BYTE_ZERO;
    end else if (uRd && (uAddr == LNK_DATA)) begin
      rdCount_q <= rdCount_q + 8'h01;
    end
  end

  // ***************************************************************
  // Read return, one cycle after the strobe
  // ***************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ownSel_q <= 1'b0;
      ownData_q <= BYTE_ZERO;
    end else begin
      ownSel_q <= uRd && !isLink(uAddr);
      if (uRd && (uAddr == HST_WR_CNT)) begin
        ownData_q <= wrCount_q;
      end else if (uRd && (uAddr == HST_RD_CNT)) begin
        ownData_q <= rdCount_q;
      end else begin
        ownData_q <= BYTE_ZERO;
      end
    end
  end

  assign uRdata = ownSel_q ? ownData_q : lnk.rdata;

endmodule : bt_host_end

// ===== bench/bt_link_sva.sv
/*
  Checks on the host link between the two ends of the block-transfer buffer.
  Assumes one clock mclk, reset nrst active low, no slave access between a
  host write and the host read two cycles after it.
*/
module bt_link_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [bt_pkg::ADDR_W-1:0] addr,
  input wire logic [bt_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [bt_pkg::DATA_W-1:0] rdata
);
  import bt_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_RD_CLR_HIDDEN:
    assert property (rd && addr == LNK_CTRL |=> !rdata[CLR_RD_BIT])
      else $error("read clear bit visible to host");
  AST_WR_CLR_HIDDEN:
    assert property (rd && addr == LNK_CTRL |=> !rdata[CLR_WR_BIT])
      else $error("write clear bit visible to host");
  AST_RDATA_IDLE:
    assert property (!rd |=> rdata == BYTE_ZERO)
      else $error("link read data without a read");
  AST_PTR_CLR_EMPTY:
    assert property (wr && addr == LNK_CTRL && wdata[CLR_RD_BIT] ##2
                     rd && addr == LNK_DATA |=> rdata == BYTE_ZERO)
      else $error("data read while read clear pending");
  AST_USER_SET:
    assert property (wr && addr == LNK_MASK && wdata[4:2] == 3'h0 ##2
                     rd && addr == LNK_MASK |=> rdata[4:2] == 3'h7)
      else $error("user flags not set by host zero");
  AST_RSV_STORE:
    assert property (wr && addr == LNK_MASK ##2 rd && addr == LNK_MASK
                     |=> rdata[6:5] == $past(wdata[6:5], 3))
      else $error("reserved bits lost host write");
  AST_SINGLE_STROBE:
    assert property (wr |-> !rd)
      else $error("link read and write together");
  AST_ADDR_RANGE:
    assert property (wr || rd |-> addr <= LNK_MASK)
      else $error("link strobe outside mapped range");
endmodule : bt_link_sva

// ===== bench/block_transfer_host_buffer_tb_top.sv
/*
  Self-checking bench: both ends joined by the link, software port on the
  host end and register port on the slave side driven by tasks.
  Assumes the package constants and one 100 MHz clock.
*/
module block_transfer_host_buffer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bt_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  addr_t uAddr = 3'h0;
  byte_t uWdata = 8'h00;
  logic uWr = 1'b0;
  logic uRd = 1'b0;
  byte_t uRdata;
  addr_t sAddr = 3'h0;
  byte_t sWdata = 8'h00;
  logic sWr = 1'b0;
  logic sRd = 1'b0;
  byte_t sRdata;
  logic slaveReset;
  logic irq;
  int fails = 0;
  int checked = 0;

  always #5 mclk = ~mclk;

  bt_link_if link ();
  block_transfer_host_buffer block_transfer_host_buffer_i (.mclk(mclk),
    .nrst(nrst), .lnk(link.devEnd), .sAddr(sAddr), .sWdata(sWdata),
    .sWr(sWr), .sRd(sRd), .sRdata(sRdata), .slaveReset(slaveReset),
    .irq(irq));
  bt_host_end bt_host_end_i (.mclk(mclk), .nrst(nrst),
    .lnk(link.hostEnd), .uAddr(uAddr), .uWdata(uWdata), .uWr(uWr),
    .uRd(uRd), .uRdata(uRdata));
  bt_link_sva bt_link_sva_i (.mclk(mclk), .nrst(nrst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));

  task stop_test();
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task cmpByte(input byte_t got, input byte_t exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpByte

  task cmpBit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpBit

  // ***************************************************************
  // Port cycles
  // ***************************************************************
  task hwr(input addr_t a, input byte_t d);
    @(posedge mclk);
    uAddr <= a;
    uWdata <= d;
    uWr <= 1'b1;
    @(posedge mclk);
    uWr <= 1'b0;
    #1;
  endtask : hwr

  task hrd(input addr_t a, input byte_t exp);
    @(posedge mclk);
    uAddr <= a;
    uRd <= 1'b1;
    @(posedge mclk);
    uRd <= 1'b0;
    #1 cmpByte(uRdata, exp);
  endtask : hrd

  task swr(input addr_t a, input byte_t d);
    @(posedge mclk);
    sAddr <= a;
    sWdata <= d;
    sWr <= 1'b1;
    @(posedge mclk);
    sWr <= 1'b0;
    #1;
  endtask : swr

  task srd(input addr_t a, input byte_t exp);
    @(posedge mclk);
    sAddr <= a;
    sRd <= 1'b1;
    @(posedge mclk);
    sRd <= 1'b0;
    #1 cmpByte(sRdata, exp);
  endtask : srd

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task tResetVals();
    srd(LNK_MASK, BYTE_ZERO);
    srd(LNK_CTRL, BYTE_ZERO);
    cmpBit(slaveReset, 1'b0);
    cmpBit(irq, 1'b0);
  endtask : tResetVals

  task tPtrClear();
    swr(SLV_CFG, 8'h01);
    hwr(LNK_DATA, 8'h33);
    swr(LNK_DATA, 8'h44);
    srd(SLV_LVL_H2S, BYTE_ZERO);
    srd(SLV_LVL_S2H, BYTE_ZERO);
    swr(SLV_CFG, 8'h03);
    hwr(LNK_CTRL, 8'h03);
    hrd(LNK_CTRL, BYTE_ZERO);
    srd(LNK_CTRL, 8'h03);
    cmpBit(irq, 1'b0);
    swr(SLV_IRQ_MASK, 8'h0f);
    cmpBit(irq, 1'b1);
    hwr(LNK_DATA, 8'haa);
    srd(SLV_LVL_H2S, BYTE_ZERO);
    swr(LNK_CTRL, 8'h03);
    srd(LNK_CTRL, 8'h03);
    swr(LNK_CTRL, 8'h02);
    srd(LNK_CTRL, 8'h02);
    swr(LNK_CTRL, 8'h00);
    srd(LNK_CTRL, BYTE_ZERO);
    srd(SLV_IRQ_STAT, 8'h03);
    swr(SLV_IRQ_STAT, 8'h0f);
    cmpBit(irq, 1'b0);
  endtask : tPtrClear

  task tToSlave();
    for (int i = 0; i < 64; i++) hwr(LNK_DATA, byte_t'(i) ^ 8'h5a);
    hwr(LNK_DATA, 8'hff);
    srd(SLV_LVL_H2S, 8'h40);
    for (int i = 0; i < 64; i++) srd(LNK_DATA, byte_t'(i) ^ 8'h5a);
    srd(LNK_DATA, BYTE_ZERO);
    swr(SLV_IRQ_STAT, 8'h0f);
  endtask : tToSlave

  task tToHost();
    for (int i = 0; i < 64; i++) swr(LNK_DATA, ~byte_t'(i));
    swr(LNK_DATA, 8'h11);
    srd(SLV_LVL_S2H, 8'h40);
    for (int i = 0; i < 64; i++) hrd(LNK_DATA, ~byte_t'(i));
    hrd(LNK_DATA, BYTE_ZERO);
    for (int i = 1; i < 4; i++) swr(LNK_DATA, byte_t'(i));
    hwr(LNK_CTRL, 8'h02);
    hrd(LNK_DATA, BYTE_ZERO);
    srd(SLV_LVL_S2H, BYTE_ZERO);
    swr(LNK_CTRL, 8'h00);
    swr(LNK_DATA, 8'h77);
    hrd(LNK_DATA, 8'h77);
    swr(SLV_IRQ_STAT, 8'h0f);
  endtask : tToHost

  task tFlags();
    hwr(LNK_MASK, 8'h1c);
    srd(LNK_MASK, BYTE_ZERO);
    hwr(LNK_MASK, 8'h80);
    hrd(LNK_MASK, 8'h1c);
    srd(LNK_MASK, 8'h9c);
    cmpBit(slaveReset, 1'b1);
    cmpBit(irq, 1'b1);
    hwr(LNK_MASK, 8'h1c);
    srd(LNK_MASK, 8'h9c);
    swr(SLV_CFG, 8'h07);
    hrd(LNK_MASK, 8'h9c);
    swr(LNK_MASK, 8'h00);
    srd(LNK_MASK, BYTE_ZERO);
    cmpBit(slaveReset, 1'b0);
    swr(LNK_MASK, 8'h10);
    srd(LNK_MASK, 8'h10);
    hwr(LNK_MASK, 8'h7c);
    hrd(LNK_MASK, 8'h70);
    swr(LNK_MASK, 8'h20);
    hrd(LNK_MASK, 8'h20);
    hwr(3'h6, 8'h55);
    hrd(3'h6, BYTE_ZERO);
  endtask : tFlags

  // Host end byte counters, then the bytes behind them reach the slave
  task tHostCount();
    hwr(HST_WR_CNT, 8'h00);
    hwr(HST_RD_CNT, 8'h00);
    hwr(LNK_DATA, 8'h21);
    hwr(LNK_DATA, 8'h22);
    hrd(LNK_DATA, BYTE_ZERO);
    hrd(HST_WR_CNT, 8'h02);
    hrd(HST_RD_CNT, 8'h01);
    srd(LNK_DATA, 8'h21);
    srd(LNK_DATA, 8'h22);
  endtask : tHostCount

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    tResetVals();
    tPtrClear();
    tToSlave();
    tToHost();
    tFlags();
    tHostCount();
    stop_test();
  end

  initial begin
    #200000;
    fails++;
    stop_test();
  end
endmodule : block_transfer_host_buffer_tb_top
